// ### loop_cfg_pkg.sv
package loop_cfg_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [14:0] IDX_CLOCK_CONTROL_TWO     = 15'h4091;
  localparam logic [14:0] IDX_LOOP_ENABLE_CONTROL   = 15'h4092;
  localparam logic [14:0] IDX_LOOP_RATIO_CONTROL    = 15'h4093;
  localparam logic [14:0] IDX_LOOP_FRACTION_MULT    = 15'h4094;
  localparam logic [14:0] IDX_LOOP_INTEGER_AND_GAIN = 15'h4095;
  localparam logic [14:0] IDX_LOOP_REFERENCE_SELECT = 15'h4096;
  localparam logic [14:0] IDX_LOOP_STATUS           = 15'h40f0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AUTO_ENABLE_BIT   = 7;
  localparam int PRESET_SEL_LSB    = 0;
  localparam int LOOP_ENABLE_BIT   = 0;
  localparam int FRACTIONAL_BIT    = 2;
  localparam int RATIO_LSB         = 0;
  localparam int INTEGER_MULT_LSB  = 5;
  localparam int GAIN_LSB          = 0;
  localparam int REF_DIVIDER_LSB   = 3;
  localparam int REF_SOURCE_LSB    = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       AUTO_ENABLE_RST   = 1'b1;
  localparam logic [2:0] PRESET_SEL_RST    = 3'h0;
  localparam logic       LOOP_ENABLE_RST   = 1'b0;
  localparam logic       FRACTIONAL_RST    = 1'b0;
  localparam logic [2:0] RATIO_RST         = 3'h0;
  localparam logic [15:0] FRACTION_RST     = 16'h0000;
  localparam logic [9:0] INTEGER_MULT_RST  = 10'h177;
  localparam logic [3:0] GAIN_RST          = 4'h0;
  localparam logic [1:0] REF_DIVIDER_RST   = 2'h0;
  localparam logic [1:0] REF_SOURCE_RST    = 2'h0;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_CRYSTAL  = 2'h0;
  localparam logic [1:0] SRC_EXTERNAL = 2'h1;
  localparam logic [3:0] GAIN_SHIFT_MAX = 4'h8;
  localparam logic [2:0] RATIO_SHIFT_MAX = 3'h4;

  // Target multiplier: 14 integer bits, 16 fraction bits
  localparam int MULT_WIDTH = 30;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01,
    BUS_HOLD = 2'b10
  } bus_state_e;

endpackage

// ### loop_config.sv
`timescale 1ns/1ps
`default_nettype none

module loop_config (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [16:0]         wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output var  logic [31:0]         wb_dat_o,
  output var  logic                wb_ack_o,
  input  wire logic                off_state_entry,
  input  wire logic                crystal_tick,
  input  wire logic                external_clock_input_tick,
  input  wire logic signed [15:0]  loop_error,
  output var  logic                loop_run,
  output var  logic                reference_tick,
  output var  logic                fractional_active,
  output var  logic [29:0]         target_multiplier,
  output var  logic signed [23:0]  scaled_error
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic        auto_config_enable_reg;
  logic [2:0]  preset_frequency_select_reg;
  logic        loop_enable_reg;
  logic        fractional_enable_reg;
  logic [2:0]  loop_freq_ratio_reg;
  logic [15:0] fraction_multiplier_reg;
  logic [9:0]  integer_multiplier_reg;
  logic [3:0]  loop_error_gain_reg;
  logic [1:0]  reference_divider_reg;
  logic [1:0]  reference_source_select_reg;
  logic [2:0]  ref_count_reg;
  logic        loop_enable_next;

  loop_cfg_pkg::bus_state_e bus_state_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic [14:0] word_index = wb_adr_i[16:2];
  wire logic        bus_req    = wb_cyc_i && wb_stb_i;
  wire logic        bus_take   = bus_req && (bus_state_reg == loop_cfg_pkg::BUS_IDLE);
  wire logic        wr_take    = bus_take && wb_we_i;

  wire logic hit_ctl2  = word_index == loop_cfg_pkg::IDX_CLOCK_CONTROL_TWO;
  wire logic hit_ena   = word_index == loop_cfg_pkg::IDX_LOOP_ENABLE_CONTROL;
  wire logic hit_ratio = word_index == loop_cfg_pkg::IDX_LOOP_RATIO_CONTROL;
  wire logic hit_frac  = word_index == loop_cfg_pkg::IDX_LOOP_FRACTION_MULT;
  wire logic hit_intg  = word_index == loop_cfg_pkg::IDX_LOOP_INTEGER_AND_GAIN;
  wire logic hit_ref   = word_index == loop_cfg_pkg::IDX_LOOP_REFERENCE_SELECT;
  wire logic hit_stat  = word_index == loop_cfg_pkg::IDX_LOOP_STATUS;

  wire logic wr_ctl2  = wr_take && hit_ctl2;
  wire logic wr_ena   = wr_take && hit_ena;
  wire logic wr_ratio = wr_take && hit_ratio;
  wire logic wr_frac  = wr_take && hit_frac;
  wire logic wr_intg  = wr_take && hit_intg;
  wire logic wr_ref   = wr_take && hit_ref;

  // Byte-lane mask: an unselected lane keeps its old bits
  // Only lanes 0 and 1 exist; sel[3:2] and the upper data half are unused
  wire logic [15:0] lane_mask;

  genvar lane;
  generate
    for (lane = 0; lane < 2; lane++) begin : g_lane
      assign lane_mask[lane*8 +: 8] = {8{wb_sel_i[lane]}};
    end
  endgenerate

  wire logic [15:0] keep_mask = ~lane_mask;
  wire logic [15:0] wr_bits   = wb_dat_i[15:0] & lane_mask;

  // ----------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------
  wire logic [15:0] img_ctl2 = {8'h00, auto_config_enable_reg, 4'h0,
                                preset_frequency_select_reg};
  wire logic [15:0] img_ena   = {13'h0000, fractional_enable_reg, 1'b0, loop_enable_reg};
  wire logic [15:0] img_ratio = {13'h0000, loop_freq_ratio_reg};
  wire logic [15:0] img_intg  = {1'b0, integer_multiplier_reg, 1'b0, loop_error_gain_reg};
  wire logic [15:0] img_ref   = {11'h000, reference_divider_reg, 1'b0,
                                 reference_source_select_reg};

  wire logic [15:0] new_ctl2  = (img_ctl2 & keep_mask) | wr_bits;
  wire logic [15:0] new_ena   = (img_ena & keep_mask) | wr_bits;
  wire logic [15:0] new_ratio = (img_ratio & keep_mask) | wr_bits;
  wire logic [15:0] new_frac  = (fraction_multiplier_reg & keep_mask) | wr_bits;
  wire logic [15:0] new_intg  = (img_intg & keep_mask) | wr_bits;
  wire logic [15:0] new_ref   = (img_ref & keep_mask) | wr_bits;

  // ----------------------------------------------------------------
  // Effective configuration
  // ----------------------------------------------------------------
  // Auto mode overrides source and divider; the stored manual fields
  // stay untouched so switching back restores them.
  wire logic [1:0] eff_source  = auto_config_enable_reg ? loop_cfg_pkg::SRC_CRYSTAL
                                                        : reference_source_select_reg;
  wire logic [1:0] eff_divider = auto_config_enable_reg ? 2'h0
                                                        : reference_divider_reg;
  wire logic       eff_frac    = !auto_config_enable_reg && fractional_enable_reg;

  wire logic src_tick = (eff_source == loop_cfg_pkg::SRC_CRYSTAL)  ? crystal_tick :
                        (eff_source == loop_cfg_pkg::SRC_EXTERNAL) ? external_clock_input_tick :
                        1'b0;

  // 2^div source ticks make one reference tick; the limit is the low
  // div bits set (0, 1, 3, 7), so divide by 8 needs no 4-bit shift
  wire logic [2:0] ref_limit = ~(3'h7 << eff_divider);
  wire logic       ref_wrap  = src_tick && (ref_count_reg >= ref_limit);

  // Loop-frequency ratio as a left shift
  wire logic [2:0] ratio_shift = loop_freq_ratio_reg[2] ? loop_cfg_pkg::RATIO_SHIFT_MAX
                                                        : loop_freq_ratio_reg;

  wire logic [3:0] gain_shift = loop_error_gain_reg[3] ? loop_cfg_pkg::GAIN_SHIFT_MAX
                                                       : loop_error_gain_reg;

  // Integer mode drops the fraction entirely
  wire logic [15:0] eff_fraction = fractional_enable_reg ? fraction_multiplier_reg
                                                         : 16'h0000;
  wire logic [29:0] nk_value  = {4'h0, integer_multiplier_reg, eff_fraction};
  wire logic [29:0] manual_mult = nk_value << ratio_shift;

  wire logic [29:0] preset_mult;

  wire logic signed [23:0] error_wide   = {{8{loop_error[15]}}, loop_error};
  wire logic signed [23:0] error_scaled = error_wide <<< gain_shift;

  // ----------------------------------------------------------------
  // Preset table
  // ----------------------------------------------------------------
  preset_rom u_preset_rom (
    .clk    (clk),
    .resetn (resetn),
    .addr   (preset_frequency_select_reg),
    .data   (preset_mult)
  );

  // ----------------------------------------------------------------
  // Enable control
  // ----------------------------------------------------------------
  // Entry to OFF wins over a write in the same cycle
  always_comb begin
    loop_enable_next = loop_enable_reg;
    if (wr_take && hit_ena) begin
      loop_enable_next = new_ena[loop_cfg_pkg::LOOP_ENABLE_BIT];
    end
    if (off_state_entry) begin
      loop_enable_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Changing auto mode while running is accepted; keeping the loop
  // off meanwhile is up to software.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      auto_config_enable_reg      <= loop_cfg_pkg::AUTO_ENABLE_RST;
      preset_frequency_select_reg <= loop_cfg_pkg::PRESET_SEL_RST;
    end else if (wr_ctl2) begin
      auto_config_enable_reg      <= new_ctl2[loop_cfg_pkg::AUTO_ENABLE_BIT];
      preset_frequency_select_reg <= new_ctl2[loop_cfg_pkg::PRESET_SEL_LSB +: 3];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loop_enable_reg       <= loop_cfg_pkg::LOOP_ENABLE_RST;
      fractional_enable_reg <= loop_cfg_pkg::FRACTIONAL_RST;
    end else begin
      loop_enable_reg <= loop_enable_next;
      if (wr_ena) begin
        fractional_enable_reg <= new_ena[loop_cfg_pkg::FRACTIONAL_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loop_freq_ratio_reg <= loop_cfg_pkg::RATIO_RST;
    end else if (wr_ratio) begin
      loop_freq_ratio_reg <= new_ratio[loop_cfg_pkg::RATIO_LSB +: 3];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fraction_multiplier_reg <= loop_cfg_pkg::FRACTION_RST;
    end else if (wr_frac) begin
      fraction_multiplier_reg <= new_frac;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      integer_multiplier_reg <= loop_cfg_pkg::INTEGER_MULT_RST;
      loop_error_gain_reg    <= loop_cfg_pkg::GAIN_RST;
    end else if (wr_intg) begin
      integer_multiplier_reg <= new_intg[loop_cfg_pkg::INTEGER_MULT_LSB +: 10];
      loop_error_gain_reg    <= new_intg[loop_cfg_pkg::GAIN_LSB +: 4];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reference_divider_reg       <= loop_cfg_pkg::REF_DIVIDER_RST;
      reference_source_select_reg <= loop_cfg_pkg::REF_SOURCE_RST;
    end else if (wr_ref) begin
      reference_divider_reg       <= new_ref[loop_cfg_pkg::REF_DIVIDER_LSB +: 2];
      reference_source_select_reg <= new_ref[loop_cfg_pkg::REF_SOURCE_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire logic [15:0] img_stat = {4'h0, gain_shift, 1'b0, ratio_shift,
                                eff_frac, auto_config_enable_reg, eff_source[0], loop_run};

  wire logic [15:0] read_value = hit_ctl2  ? img_ctl2 :
                                 hit_ena   ? img_ena :
                                 hit_ratio ? img_ratio :
                                 hit_frac  ? fraction_multiplier_reg :
                                 hit_intg  ? img_intg :
                                 hit_ref   ? img_ref :
                                 hit_stat  ? img_stat :
                                 16'h0000;

  // ----------------------------------------------------------------
  // Wishbone handshake
  // ----------------------------------------------------------------
  // Ack one cycle after the request is seen, then one idle cycle so a
  // held request is never taken twice.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_state_reg <= loop_cfg_pkg::BUS_IDLE;
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= 32'h00000000;
    end else begin
      case (bus_state_reg)
        loop_cfg_pkg::BUS_IDLE: begin
          wb_ack_o <= bus_take;
          if (bus_take) begin
            bus_state_reg <= loop_cfg_pkg::BUS_ACK;
            wb_dat_o      <= wb_we_i ? 32'h00000000 : {16'h0000, read_value};
          end
        end
        loop_cfg_pkg::BUS_ACK: begin
          wb_ack_o      <= 1'b0;
          bus_state_reg <= loop_cfg_pkg::BUS_HOLD;
        end
        loop_cfg_pkg::BUS_HOLD: begin
          wb_ack_o      <= 1'b0;
          bus_state_reg <= loop_cfg_pkg::BUS_IDLE;
        end
        default: begin
          wb_ack_o      <= 1'b0;
          bus_state_reg <= loop_cfg_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Reference divider
  // ----------------------------------------------------------------
  // Counter runs only with the loop on, which saves toggling when off
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_count_reg  <= 3'h0;
      reference_tick <= 1'b0;
    end else if (!loop_enable_reg) begin
      ref_count_reg  <= 3'h0;
      reference_tick <= 1'b0;
    end else begin
      reference_tick <= ref_wrap;
      if (ref_wrap) begin
        ref_count_reg <= 3'h0;
      end else if (src_tick) begin
        ref_count_reg <= ref_count_reg + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Loop outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loop_run          <= 1'b0;
      fractional_active <= 1'b0;
    end else begin
      loop_run          <= loop_enable_reg;
      fractional_active <= loop_enable_reg && eff_frac;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      target_multiplier <= 30'h00000000;
    end else if (!loop_enable_reg) begin
      target_multiplier <= 30'h00000000;
    end else if (auto_config_enable_reg) begin
      target_multiplier <= preset_mult;
    end else begin
      target_multiplier <= manual_mult;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scaled_error <= 24'sh000000;
    end else begin
      scaled_error <= loop_enable_reg ? error_scaled : 24'sh000000;
    end
  end

endmodule // loop_config

`default_nettype wire

// ### loop_config_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port checks
// ----------------------------------------------------------------
module loop_config_properties (
  input wire logic               clk,
  input wire logic               resetn,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  input wire logic               off_state_entry,
  input wire logic               crystal_tick,
  input wire logic               external_clock_input_tick,
  input wire logic               loop_run,
  input wire logic               reference_tick,
  input wire logic               fractional_active,
  input wire logic [29:0]        target_multiplier,
  input wire logic signed [23:0] scaled_error
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_request: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_write_ack_quiet: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
    else $error("write ack carries data");
  a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper read bits set");
  a_off_stops_loop: assert property (off_state_entry |-> ##2 !loop_run)
    else $error("loop runs after off entry");
  a_idle_outputs_zero: assert property (!loop_run && $past(!loop_run) |->
    target_multiplier == 30'h0 && scaled_error == 24'sh0 && !fractional_active)
    else $error("outputs live while loop off");
  a_frac_needs_run: assert property (fractional_active |-> loop_run)
    else $error("fractional without loop");
  a_ref_from_source: assert property (reference_tick |->
    $past(crystal_tick || external_clock_input_tick))
    else $error("reference tick without source tick");
  a_ref_needs_run: assert property (reference_tick |-> loop_run)
    else $error("reference tick while loop off");
endmodule // loop_config_properties

bind loop_config loop_config_properties u_props (.clk, .resetn, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_dat_o, .wb_ack_o, .off_state_entry, .crystal_tick,
  .external_clock_input_tick, .loop_run, .reference_tick, .fractional_active,
  .target_multiplier, .scaled_error);
`default_nettype wire

// ### preset_rom.sv
`timescale 1ns/1ps
`default_nettype none

module preset_rom (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [2:0]  addr,
  output var  logic [29:0] data
);

  // ----------------------------------------------------------------
  // Preset output frequency over the 32.768 kHz reference, 14.16
  // ----------------------------------------------------------------
  logic [29:0] table_value;

  always_comb begin
    case (addr)
      3'h0: table_value = 30'h003e8000;  // 2.048 MHz
      3'h1: table_value = 30'h01588800;  // 11.2896 MHz
      3'h2: table_value = 30'h016e3600;  // 12 MHz
      3'h3: table_value = 30'h01770000;  // 12.288 MHz
      3'h4: table_value = 30'h0249f000;  // 19.2 MHz
      3'h5: table_value = 30'h02b11000;  // 22.5792 MHz
      3'h6: table_value = 30'h02dc6c00;  // 24 MHz
      3'h7: table_value = 30'h02ee0000;  // 24.576 MHz
      default: table_value = 30'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data <= 30'h00000000;
    end else begin
      data <= table_value;
    end
  end

endmodule // preset_rom

`default_nettype wire

// ### tb_loop_config.sv
`timescale 1ns/1ps
`default_nettype none
module tb_loop_config;
  // ----------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------
  logic               clk;
  logic               resetn;
  logic               wb_cyc_i;
  logic               wb_stb_i;
  logic               wb_we_i;
  logic [16:0]        wb_adr_i;
  logic [3:0]         wb_sel_i;
  logic [31:0]        wb_dat_i;
  logic [31:0]        wb_dat_o;
  logic               wb_ack_o;
  logic               off_state_entry;
  logic               crystal_tick;
  logic               ext_tick;
  logic signed [15:0] loop_error;
  logic               loop_run;
  logic               reference_tick;
  logic               fractional_active;
  logic [29:0]        target_multiplier;
  logic signed [23:0] scaled_error;
  int                 bad_count;
  int                 n_checks;
  int                 ref_count = 0;
  // Last entry is an unmapped index
  localparam logic [14:0] R_IDX [7] = '{15'h4091, 15'h4092, 15'h4093, 15'h4094, 15'h4095,
                                        15'h4096, 15'h4097};
  localparam logic [15:0] R_RST [7] = '{16'h0080, 16'h0, 16'h0, 16'h0, 16'h2ee0, 16'h0, 16'h0};
  localparam logic [15:0] R_MSK [7] = '{16'h0087, 16'h0005, 16'h0007, 16'hffff, 16'h7fef,
                                        16'h001b, 16'h0};
  localparam logic [29:0] PRESET [8] = '{30'h03e8000, 30'h1588800, 30'h16e3600, 30'h1770000,
                                         30'h249f000, 30'h2b11000, 30'h2dc6c00, 30'h2ee0000};

  loop_config dut (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .off_state_entry(off_state_entry),
    .crystal_tick(crystal_tick), .external_clock_input_tick(ext_tick),
    .loop_error(loop_error), .loop_run(loop_run), .reference_tick(reference_tick),
    .fractional_active(fractional_active), .target_multiplier(target_multiplier),
    .scaled_error(scaled_error));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (reference_tick === 1'b1) ref_count <= ref_count + 1;
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; leaves one idle cycle behind
  task automatic wb_cycle(input logic we, input logic [14:0] idx, input logic [15:0] wd,
                          output logic [15:0] rd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, wd};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [14:0] idx, input logic [15:0] wd);
    logic [15:0] rd;
    wb_cycle(1'b1, idx, wd, rd);
  endtask

  task automatic rd_check(input logic [14:0] idx, input logic [15:0] exp);
    logic [15:0] rd;
    wb_cycle(1'b0, idx, 16'h0, rd);
    check({16'h0, rd}, {16'h0, exp});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_regs();
    for (int i = 0; i < 7; i++) begin
      rd_check(R_IDX[i], R_RST[i]);
      wr(R_IDX[i], 16'hffff);
      rd_check(R_IDX[i], R_MSK[i]);
      wr(R_IDX[i], R_RST[i]);
    end
    $display("registers done");
  endtask

  task automatic test_auto();
    wr(15'h4096, 16'h0019);
    wr(15'h4093, 16'h0004);
    repeat (3) @(posedge clk);
    check(loop_run, 1'b0);
    check(target_multiplier, 30'h0);
    wr(15'h4092, 16'h0005);
    for (int c = 0; c < 8; c++) begin
      wr(15'h4091, 16'h0080 | 16'(c));
      repeat (3) @(posedge clk);
      check(target_multiplier, PRESET[c]);
      check(fractional_active, 1'b0);
    end
    wr(15'h4092, 16'h0000);
    wr(15'h4093, 16'h0000);
    wr(15'h4096, 16'h0000);
    $display("auto done");
  endtask

  task automatic test_manual();
    logic [29:0] v;
    int          sh;
    wr(15'h4091, 16'h0000);
    wr(15'h4094, 16'h3126);
    wr(15'h4095, 16'h14a0);
    for (int r = 0; r < 8; r++) begin
      wr(15'h4093, 16'(r));
      wr(15'h4092, {13'h0, r[0], 2'b01});
      repeat (3) @(posedge clk);
      sh = r[2] ? 4 : r[1:0];
      v = {4'h0, 10'h0a5, r[0] ? 16'h3126 : 16'h0000};
      check(target_multiplier, v << sh);
      check(fractional_active, r[0]);
    end
    rd_check(15'h40f0, 16'h0049);
    $display("manual done");
  endtask

  task automatic test_gain();
    logic signed [23:0] e;
    loop_error <= 16'sh8123;
    for (int g = 0; g < 16; g++) begin
      wr(15'h4095, 16'h14a0 | 16'(g));
      repeat (3) @(posedge clk);
      e = {{8{loop_error[15]}}, loop_error} <<< (g > 7 ? 8 : g);
      check(scaled_error, e);
    end
    wr(15'h4095, 16'h2ee0);
    $display("gain done");
  endtask

  task automatic ref_case(input logic [15:0] ctl2, input logic [15:0] rsel,
                          input logic [1:0] which, input int exp_n);
    int base;
    wr(15'h4092, 16'h0000);
    wr(15'h4091, ctl2);
    wr(15'h4096, rsel);
    wr(15'h4092, 16'h0001);
    base = ref_count;
    repeat (8) begin
      crystal_tick <= which[0];
      ext_tick     <= which[1];
      @(posedge clk);
      crystal_tick <= 1'b0;
      ext_tick     <= 1'b0;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    check(ref_count - base, exp_n);
  endtask

  task automatic test_refs();
    ref_case(16'h0000, 16'h0000, 2'b01, 8);
    ref_case(16'h0000, 16'h0009, 2'b10, 4);
    ref_case(16'h0000, 16'h0011, 2'b10, 2);
    ref_case(16'h0000, 16'h0018, 2'b01, 1);
    ref_case(16'h0000, 16'h0001, 2'b01, 0);
    ref_case(16'h0000, 16'h0002, 2'b11, 0);
    ref_case(16'h0080, 16'h0019, 2'b01, 8);
    ref_case(16'h0080, 16'h0019, 2'b10, 0);
    $display("reference done");
  endtask

  task automatic test_off();
    wr(15'h4092, 16'h0001);
    repeat (2) @(posedge clk);
    check(loop_run, 1'b1);
    off_state_entry <= 1'b1;
    @(posedge clk);
    off_state_entry <= 1'b0;
    repeat (3) @(posedge clk);
    check(loop_run, 1'b0);
    rd_check(15'h4092, 16'h0000);
    $display("off state done");
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  initial begin
    resetn = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 17'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    off_state_entry = 1'b0;
    crystal_tick = 1'b0;
    ext_tick = 1'b0;
    loop_error = 16'sh0;
    bad_count = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    test_regs();
    test_auto();
    test_manual();
    test_gain();
    test_refs();
    test_off();
    end_sim();
  end
endmodule // tb_loop_config
`default_nettype wire
